// ===== sfsp_pkg.sv
// Constants, opcodes and status layout for the serial byte-memory slave port
// Summary of operation
// - Select high: standby, ignore inputs, output off
// - Sample input on SCK rise, shift on fall
// - SCK rate well below ref_clk_i / 4, pauses keep transfer state
// - Drive output only for read data, never during hold
// - Protect pin plus enable bit block status writes
// - Hold low freezes operation, ignores SCK and select
// - Each data byte committed once fully received
// - Only SPI mode 0 or mode 3
// - 32768 byte locations, 15-bit address
// - Read-only identification bytes available
// - Write-disable command and quarter/half/full block protect
// - First byte after select is the opcode
// - Two-byte address MSB first, top bit ignored
// - Unknown opcode ignored until next select
// - SCK level at select picks mode 0/3
package sfsp_pkg;

    // Command opcodes
    localparam logic [7:0] OP_WRSR  = 8'h01;
    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [7:0] OP_READ  = 8'h03;
    localparam logic [7:0] OP_WRDI  = 8'h04;
    localparam logic [7:0] OP_RDSR  = 8'h05;
    localparam logic [7:0] OP_WREN  = 8'h06;
    localparam logic [7:0] OP_RDID  = 8'h9f;

    // Status register layout
    localparam int STAT_PIN_EN = 7;             // Protect pin enable bit
    localparam int STAT_BP_HI  = 3;             // Block protect field
    localparam int STAT_BP_LO  = 2;
    localparam int STAT_WEL    = 1;             // Write enable latch
    localparam logic [7:0] STAT_WR_MASK = 8'h8c; // Bits software may write
    localparam logic [7:0] STAT_RST     = 8'h00; // Status after reset

    // Block protect encodings
    localparam logic [1:0] BP_NONE    = 2'h0;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF    = 2'h2;

    // Bit counter reset value and last bit of a byte
    localparam logic [2:0] BIT_RST  = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // Transfer states
    typedef enum logic [2:0] {
        SFSP_OPCODE,
        SFSP_ADDR_HI,
        SFSP_ADDR_LO,
        SFSP_WDATA,
        SFSP_RDATA,
        SFSP_WSTAT,
        SFSP_RSTAT,
        SFSP_IGNORE
    } sfsp_state_t;

    localparam int ID_IDX_W = 2;                 // Identification index width

endpackage : sfsp_pkg

// ===== sfsp_port.sv
// Serial slave port of a byte-wide nonvolatile memory, with status and id
`timescale 1ns/10ps
module sfsp_port #(
    parameter int          ADDR_W   = 15,        // Byte address width
    parameter logic [23:0] ID_VALUE = 24'h5a_21_03 // Arbitrary id: maker, density, revision
) (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    // Serial pins, asynchronous to ref_clk_i
    input  wire logic cs_n_i,
    input  wire logic sck_i,
    input  wire logic si_i,
    input  wire logic hold_n_i,
    input  wire logic wp_n_i,
    // Serial output pin with its enable
    output logic      so_o,
    output logic      so_oe_o,
    // Observation
    output logic      spi_mode3_o,
    output logic [7:0] status_o
);

    // Address width must fit the two-byte address
    if (ADDR_W < 9 || ADDR_W > 16) begin : g_bad_width
        $error("ADDR_W must be 9 to 16");
    end

    // Two-flop synchronisers; the first stage feeds only the second
    logic [4:0] pin_meta_q;
    logic [4:0] pin_sync_q;
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_meta_q <= 5'h1b;
            pin_sync_q <= 5'h1b;
        end else begin
            pin_meta_q <= {cs_n_i, sck_i, si_i, hold_n_i, wp_n_i};
            pin_sync_q <= pin_meta_q;
        end
    end

    logic cs_s, sck_s, si_s, hold_s, wp_s;       // Synchronised pin levels
    assign {cs_s, sck_s, si_s, hold_s, wp_s} = pin_sync_q;

    // Edge history; select history frozen during hold
    logic sck_q;
    logic cs_q;
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sck_q <= 1'b0;
            cs_q  <= 1'b1;
        end else begin
            sck_q <= sck_s;                      // Level history, no timeout, so pauses keep state
            if (hold_s) begin
                cs_q <= cs_s;
            end
        end
    end

    // Edge events; SCK is oversampled, so its rate must stay well below ref_clk_i / 4
    logic active, sck_rise, sck_fall, cs_fall, standby;
    assign active   = !cs_s && hold_s;
    assign sck_rise = active && sck_s && !sck_q;
    assign sck_fall = active && !sck_s && sck_q;
    assign cs_fall  = hold_s && !cs_s && cs_q;
    assign standby  = hold_s && cs_s;

    // Block protect decode of one address
    function automatic logic is_protected(input logic [ADDR_W-1:0] a, input logic [1:0] bp);
        logic [1:0] top;
        top = a[ADDR_W-1 -: 2];
        case (bp)
            sfsp_pkg::BP_NONE:    is_protected = 1'b0;
            sfsp_pkg::BP_QUARTER: is_protected = (top == 2'h3);
            sfsp_pkg::BP_HALF:    is_protected = top[1];
            default:              is_protected = 1'b1;          // Whole array shut
        endcase
    endfunction : is_protected

    // Transfer state and shift registers
    sfsp_pkg::sfsp_state_t state_q;
    logic [2:0]         bit_cnt_q;               // Bits received in this byte
    logic [7:0]         rx_q;                    // Incoming shift register
    logic [7:0]         cmd_q;                   // Opcode of this selection
    logic [ADDR_W-1:0]  addr_q;                  // Running byte address
    logic [7:0]         rd_byte_q;               // Byte being shifted out
    logic [sfsp_pkg::ID_IDX_W-1:0] id_idx_q;     // Next id byte
    logic [7:0]         stat_q;                  // Status register
    logic               mode3_q;                 // Clock mode seen at select

    // Memory array, not reset: contents survive reset
    logic [7:0] mem [2**ADDR_W];

    logic [7:0] rx_byte;                         // Byte completed on this rise
    logic       byte_done;
    logic [ADDR_W-1:0] addr_full;                // Address with low byte just received
    logic       mem_we;
    logic       stat_we;
    assign rx_byte   = {rx_q[6:0], si_s};
    assign byte_done = sck_rise && (bit_cnt_q == sfsp_pkg::BIT_LAST);
    assign addr_full = {addr_q[ADDR_W-1:8], rx_byte};
    // Commit as soon as the byte is whole, no busy time
    assign mem_we  = byte_done && (state_q == sfsp_pkg::SFSP_WDATA) && stat_q[sfsp_pkg::STAT_WEL]
                     && !is_protected(addr_q, stat_q[sfsp_pkg::STAT_BP_HI:sfsp_pkg::STAT_BP_LO]);
    // Pin and enable bit together lock the status register
    assign stat_we = byte_done && (state_q == sfsp_pkg::SFSP_WSTAT) && stat_q[sfsp_pkg::STAT_WEL]
                     && !(!wp_s && stat_q[sfsp_pkg::STAT_PIN_EN]);

    // Id byte selection, most significant byte first
    function automatic logic [7:0] id_byte(input logic [sfsp_pkg::ID_IDX_W-1:0] i);
        case (i)
            2'h0:    id_byte = ID_VALUE[23:16];
            2'h1:    id_byte = ID_VALUE[15:8];
            default: id_byte = ID_VALUE[7:0];
        endcase
    endfunction : id_byte

    // Bit counter and input shift, rising edges only
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bit_cnt_q <= sfsp_pkg::BIT_RST;
            rx_q      <= 8'h00;
        end else if (standby) begin
            bit_cnt_q <= sfsp_pkg::BIT_RST;
        end else if (sck_rise) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            rx_q      <= rx_byte;
        end
    end

    // Clock mode caught at the select edge
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode3_q <= 1'b0;
        end else if (cs_fall) begin
            mode3_q <= sck_s;
        end
    end

    // Command sequencer
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q  <= sfsp_pkg::SFSP_OPCODE;
            cmd_q    <= 8'h00;
            addr_q   <= '0;
            id_idx_q <= '0;
        end else if (standby) begin
            state_q  <= sfsp_pkg::SFSP_OPCODE;
            id_idx_q <= '0;
        end else if (byte_done) begin
            case (state_q)
                // First byte of a selection is the opcode
                sfsp_pkg::SFSP_OPCODE: begin
                    cmd_q <= rx_byte;
                    case (rx_byte)
                        sfsp_pkg::OP_READ,
                        sfsp_pkg::OP_WRITE: state_q <= sfsp_pkg::SFSP_ADDR_HI;
                        sfsp_pkg::OP_WRSR:  state_q <= sfsp_pkg::SFSP_WSTAT;
                        sfsp_pkg::OP_RDSR:  state_q <= sfsp_pkg::SFSP_RSTAT;
                        sfsp_pkg::OP_RDID: begin
                            state_q  <= sfsp_pkg::SFSP_RDATA;
                            id_idx_q <= 2'h1;
                        end
                        // Single-byte commands and unknown ones idle out
                        default:            state_q <= sfsp_pkg::SFSP_IGNORE;
                    endcase
                end
                // Top bit of the high byte is dropped
                sfsp_pkg::SFSP_ADDR_HI: begin
                    addr_q[ADDR_W-1:8] <= rx_byte[ADDR_W-9:0];
                    state_q            <= sfsp_pkg::SFSP_ADDR_LO;
                end
                sfsp_pkg::SFSP_ADDR_LO: begin
                    addr_q  <= (cmd_q == sfsp_pkg::OP_READ) ? addr_full + 1'b1 : addr_full;
                    state_q <= (cmd_q == sfsp_pkg::OP_READ) ? sfsp_pkg::SFSP_RDATA
                                                            : sfsp_pkg::SFSP_WDATA;
                end
                // Sequential access wraps at the top of the array
                sfsp_pkg::SFSP_WDATA: addr_q <= addr_q + 1'b1;
                sfsp_pkg::SFSP_RDATA: begin
                    if (cmd_q == sfsp_pkg::OP_RDID) begin
                        if (id_idx_q != 2'h3) begin
                            id_idx_q <= id_idx_q + 2'h1;
                        end
                    end else begin
                        addr_q <= addr_q + 1'b1;
                    end
                end
                sfsp_pkg::SFSP_WSTAT:  state_q <= sfsp_pkg::SFSP_IGNORE;
                sfsp_pkg::SFSP_RSTAT:  state_q <= sfsp_pkg::SFSP_RSTAT;
                sfsp_pkg::SFSP_IGNORE: state_q <= sfsp_pkg::SFSP_IGNORE;
                default:               state_q <= sfsp_pkg::SFSP_IGNORE;
            endcase
        end
    end

    // Byte writes into the array
    always_ff @(posedge ref_clk_i) begin
        if (mem_we) begin
            mem[addr_q] <= rx_byte;
        end
    end

    // Status register and write enable latch
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stat_q <= sfsp_pkg::STAT_RST;
        end else if (stat_we) begin
            stat_q <= (rx_byte & sfsp_pkg::STAT_WR_MASK) | (stat_q & ~sfsp_pkg::STAT_WR_MASK);
        end else if (byte_done && state_q == sfsp_pkg::SFSP_OPCODE && rx_byte == sfsp_pkg::OP_WREN) begin
            stat_q[sfsp_pkg::STAT_WEL] <= 1'b1;
        end else if (byte_done && state_q == sfsp_pkg::SFSP_OPCODE && rx_byte == sfsp_pkg::OP_WRDI) begin
            stat_q[sfsp_pkg::STAT_WEL] <= 1'b0;
        end else if (standby && (cmd_q == sfsp_pkg::OP_WRITE || cmd_q == sfsp_pkg::OP_WRSR)
                     && state_q != sfsp_pkg::SFSP_OPCODE) begin
            stat_q[sfsp_pkg::STAT_WEL] <= 1'b0;  // Latch spent by a finished write
        end
    end

    // Next outgoing byte, loaded when a byte boundary is reached
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_byte_q <= 8'h00;
        end else if (byte_done) begin
            if (state_q == sfsp_pkg::SFSP_OPCODE && rx_byte == sfsp_pkg::OP_RDSR) begin
                rd_byte_q <= stat_q;
            end else if (state_q == sfsp_pkg::SFSP_OPCODE && rx_byte == sfsp_pkg::OP_RDID) begin
                rd_byte_q <= id_byte(2'h0);
            end else if (state_q == sfsp_pkg::SFSP_ADDR_LO) begin
                rd_byte_q <= mem[addr_full];
            end else if (state_q == sfsp_pkg::SFSP_RDATA && cmd_q == sfsp_pkg::OP_RDID) begin
                rd_byte_q <= id_byte(id_idx_q);
            end else if (state_q == sfsp_pkg::SFSP_RDATA) begin
                rd_byte_q <= mem[addr_q];
            end else if (state_q == sfsp_pkg::SFSP_RSTAT) begin
                rd_byte_q <= stat_q;
            end
        end
    end

    // Output shifts on falling edges of read phases only
    logic rd_phase;
    logic so_q, so_en_q;
    assign rd_phase = (state_q == sfsp_pkg::SFSP_RDATA) || (state_q == sfsp_pkg::SFSP_RSTAT);
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            so_q    <= 1'b0;
            so_en_q <= 1'b0;
        end else if (standby) begin
            so_en_q <= 1'b0;
        end else if (sck_fall && rd_phase) begin
            so_q    <= rd_byte_q[sfsp_pkg::BIT_LAST - bit_cnt_q];
            so_en_q <= 1'b1;
        end
    end

    // Enable drops at once with hold or deselect
    assign so_o        = so_q;
    assign so_oe_o     = so_en_q && rd_phase && hold_s && !cs_s;
    assign spi_mode3_o = mode3_q;
    assign status_o    = stat_q;

    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_so_off_deselect: assert property (cs_s |-> !so_oe_o) else $error("output driven while deselected");
    a_so_off_hold: assert property (!hold_s |-> !so_oe_o) else $error("output driven during hold");
    a_so_only_read: assert property (so_oe_o |-> rd_phase) else $error("output driven outside read");
    a_stat_locked: assert property (byte_done && state_q == sfsp_pkg::SFSP_WSTAT && !wp_s
        && stat_q[sfsp_pkg::STAT_PIN_EN] |=> stat_q == $past(stat_q)) else $error("status written while locked");
    a_hold_freeze: assert property (!hold_s |=> state_q == $past(state_q) && bit_cnt_q == $past(bit_cnt_q)
        && rx_q == $past(rx_q)) else $error("state moved during hold");
    a_deselect_clears: assert property (standby |=> state_q == sfsp_pkg::SFSP_OPCODE
        && bit_cnt_q == sfsp_pkg::BIT_RST) else $error("deselect did not clear");
    a_byte_commit: assert property (mem_we |=> mem[$past(addr_q)] == $past(rx_byte))
        else $error("byte not committed");
    a_bad_op_stays: assert property (state_q == sfsp_pkg::SFSP_IGNORE && !standby |=> state_q == sfsp_pkg::SFSP_IGNORE)
        else $error("left ignore state early");
    a_mode_capture: assert property (cs_fall |=> mode3_q == $past(sck_s)) else $error("mode not captured");
    a_rx_rise_only: assert property (!sck_rise |=> rx_q == $past(rx_q)) else $error("input sampled off edge");
    a_opcode_wren: assert property (byte_done && state_q == sfsp_pkg::SFSP_OPCODE && rx_byte == sfsp_pkg::OP_WREN
        |=> stat_q[sfsp_pkg::STAT_WEL] ##1 state_q == sfsp_pkg::SFSP_IGNORE) else $error("opcode not decoded");

    c_mem_write: cover property (mem_we);
    c_read_out: cover property (so_oe_o && state_q == sfsp_pkg::SFSP_RDATA);
    c_hold_in_read: cover property (rd_phase && !hold_s);
    c_mode3_select: cover property (cs_fall && sck_s);

endmodule : sfsp_port

// ===== sfsp_master_model.sv
// Behavioural bus master model that drives the serial pins of the slave port
`timescale 1ns/10ps
module sfsp_master_model (
    // Pacing clock
    input  wire logic ref_clk_i,
    // Serial pins
    output logic      cs_n_o,
    output logic      sck_o,
    output logic      si_o,
    output logic      hold_n_o,
    input  wire logic so_i,
    input  wire logic so_oe_i
);
    int   hold_at  = -1;   // Bit where a hold goes in, -1 for none
    int   pause_at = -1;   // Bit where the clock parks, -1 for none
    logic mode3    = 1'b0; // Idle clock level of this frame
    logic oe_seen  = 1'b0; // Output driven at some point in the frame
    logic hold_oe  = 1'b0; // Output enable seen during the last hold
    logic last_so  = 1'b0; // Last bit taken from the output

    // Idle pins, with the link clock parked low
    initial begin
        cs_n_o   = 1'b1;
        sck_o    = 1'b0;
        si_o     = 1'b0;
        hold_n_o = 1'b1;
    end

    // Remember any output drive while selected
    always @(posedge ref_clk_i) begin
        if (!cs_n_o && so_oe_i) begin
            oe_seen <= 1'b1;
        end
    end

    // Half a link clock period is 4 system cycles, 800 ns per bit
    task automatic half(input int n);
        repeat (n * 4) @(negedge ref_clk_i);
    endtask : half

    // Park the clock at the idle level, then a fresh select fall
    task automatic start(input logic m3);
        mode3  = m3;
        sck_o  = m3;
        half(1);
        cs_n_o = 1'b0;
        oe_seen = 1'b0;
        half(1);
    endtask : start

    // Return clock to idle, deselect, release the data line
    task automatic stop();
        if (!mode3) begin
            sck_o = 1'b0;
        end
        half(1);
        cs_n_o = 1'b1;
        si_o   = ~si_o;   // Released line shows no stale value
        half(2);
    endtask : stop

    // Shift n bits MSB first; output taken at each rise
    task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < n; i++) begin
            sck_o = 1'b0;
            si_o  = tx[7 - i]; // set while clock low
            half(1);
            if (i == pause_at) begin
                half(20);      // clock paused mid byte
            end
            if (i == hold_at) begin
                hold_n_o = 1'b0; // only with the clock low
                half(1);
                hold_oe  = so_oe_i;
                sck_o    = 1'b1; // Edges that must be ignored
                half(1);
                sck_o    = 1'b0;
                half(1);
                hold_n_o = 1'b1;
                half(1);
            end
            rx[7 - i] = so_oe_i ? so_i : ~last_so;
            last_so   = rx[7 - i];
            sck_o     = 1'b1;
            half(1);
        end
    endtask : xfer
endmodule : sfsp_master_model

// ===== sfsp_port_bench.sv
// Self-checking bench for the serial byte-memory slave port
`timescale 1ns/10ps
module sfsp_port_bench;
    localparam logic [23:0] ID_BENCH = 24'h3c_15_07; // Arbitrary id value

    logic       ref_clk_i = 1'b0; // System clock, 10 MHz
    logic       rst_n_i   = 1'b0; // Async reset
    logic       wp_n_i    = 1'b1; // Protect pin
    logic       cs_n, sck, si, hold_n, so, so_oe, mode3;
    logic [7:0] status;
    logic [7:0] rxb [0:4];        // Bytes seen in the last frame
    int         n_fail  = 0;
    int         n_tests = 0;

    // Clock generator
    always #50 ref_clk_i = ~ref_clk_i;

    sfsp_port #(.ADDR_W(15), .ID_VALUE(ID_BENCH)) sfsp_port_inst (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
        .hold_n_i(hold_n), .wp_n_i(wp_n_i), .so_o(so), .so_oe_o(so_oe), .spi_mode3_o(mode3),
        .status_o(status));

    sfsp_master_model sfsp_master_model_inst (
        .ref_clk_i(ref_clk_i), .cs_n_o(cs_n), .sck_o(sck), .si_o(si), .hold_n_o(hold_n),
        .so_i(so), .so_oe_i(so_oe));

    // Byte compare
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8

    // Flag compare
    task automatic chk1(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask : chk1

    // One command frame: opcode then nb trailing bytes from tail
    task automatic frame(input logic m3, input logic [7:0] op, input logic [31:0] tail, input int nb);
        sfsp_master_model_inst.start(m3);
        sfsp_master_model_inst.xfer(op, 8, rxb[0]);
        for (int k = 0; k < nb; k++) begin
            sfsp_master_model_inst.xfer(tail[31 - 8 * k -: 8], 8, rxb[k + 1]);
        end
        sfsp_master_model_inst.stop();
    endtask : frame

    // Latch set, then one byte written
    task automatic wr_mem(input logic [15:0] a, input logic [7:0] d);
        frame(1'b0, sfsp_pkg::OP_WREN, 32'h0, 0);
        frame(1'b0, sfsp_pkg::OP_WRITE, {a, d, 8'h00}, 3);
    endtask : wr_mem

    // Latch set, then status written
    task automatic wr_stat(input logic [7:0] v);
        frame(1'b0, sfsp_pkg::OP_WREN, 32'h0, 0);
        frame(1'b0, sfsp_pkg::OP_WRSR, {v, 24'h0}, 1);
    endtask : wr_stat

    // Two bytes read from a; results in rxb[3] and rxb[4]
    task automatic rd_mem(input logic m3, input logic [15:0] a);
        frame(m3, sfsp_pkg::OP_READ, {a, 16'h0}, 4);
    endtask : rd_mem

    // Status read twice over, compared each time and at the port
    task automatic rd_stat(input logic [7:0] exp);
        frame(1'b0, sfsp_pkg::OP_RDSR, 32'h0, 2);
        chk8("status byte", exp, rxb[1]);
        chk8("status repeat", exp, rxb[2]);
        chk8("status port", exp, status);
    endtask : rd_stat

    // Counts, verdict, end of run
    task automatic close_out();
        $display("Comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out

    // Watchdog, far beyond the expected 1 ms of traffic
    initial begin
        #8_000_000;
        n_fail++;
        $display("Error watchdog expired");
        close_out();
    end

    // Main sequence
    initial begin
        repeat (10) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        repeat (3) @(negedge ref_clk_i);
        rd_stat(sfsp_pkg::STAT_RST);
        chk1("idle output enable", 1'b0, so_oe);
        $display("test reset done");
        // Burst across the top of the array, read back at once
        frame(1'b0, sfsp_pkg::OP_WREN, 32'h0, 0);
        frame(1'b0, sfsp_pkg::OP_WRITE, {16'h7fff, 8'ha5, 8'h3c}, 4);
        rd_mem(1'b1, 16'hffff);
        chk8("top byte", 8'ha5, rxb[3]);
        chk8("wrapped byte", 8'h3c, rxb[4]);
        chk1("mode 3 seen", 1'b1, mode3);
        rd_mem(1'b0, 16'h0000);
        chk8("byte zero", 8'h3c, rxb[3]);
        chk1("mode 0 seen", 1'b0, mode3);
        $display("test burst done");
        // Latch handling
        rd_stat(8'h00);
        frame(1'b0, sfsp_pkg::OP_WRITE, {16'h0000, 8'h11, 8'h00}, 3);
        frame(1'b0, sfsp_pkg::OP_WREN, 32'h0, 0);
        rd_stat(8'h02);
        frame(1'b0, sfsp_pkg::OP_WRDI, 32'h0, 0);
        frame(1'b0, sfsp_pkg::OP_WRITE, {16'h0000, 8'h22, 8'h00}, 3);
        rd_mem(1'b0, 16'h0000);
        chk8("write without latch", 8'h3c, rxb[3]);
        $display("test latch done");
        // Quarter protect boundary, pin guard, full protect
        wr_mem(16'h6000, 8'h55);
        wr_stat(8'h84);
        rd_stat(8'h84);
        wr_mem(16'h5fff, 8'h66);
        wr_mem(16'h6000, 8'h77);
        rd_mem(1'b0, 16'h5fff);
        chk8("below quarter", 8'h66, rxb[3]);
        chk8("in quarter", 8'h55, rxb[4]);
        @(negedge ref_clk_i) wp_n_i = 1'b0;
        wr_stat(8'h00);
        rd_stat(8'h84);
        @(negedge ref_clk_i) wp_n_i = 1'b1;
        wr_stat(8'h8c);
        wr_mem(16'h0000, 8'h99);
        rd_mem(1'b0, 16'h0000);
        chk8("all protected", 8'h3c, rxb[3]);
        // Half protect: lower half open, upper half shut
        wr_stat(8'h08);
        rd_stat(8'h08);
        wr_mem(16'h3fff, 8'h12);
        wr_mem(16'h5fff, 8'haa);
        rd_mem(1'b0, 16'h3fff);
        chk8("below half", 8'h12, rxb[3]);
        rd_mem(1'b0, 16'h5fff);
        chk8("in half", 8'h66, rxb[3]);
        wr_stat(8'h00);
        rd_stat(8'h00);
        $display("test protect done");
        // Unknown opcode with a latch-set byte after it; cut opcode
        frame(1'b0, 8'hab, {sfsp_pkg::OP_WREN, 24'h0}, 3);
        chk1("unknown opcode drive", 1'b0, sfsp_master_model_inst.oe_seen);
        sfsp_master_model_inst.start(1'b0);
        sfsp_master_model_inst.xfer(sfsp_pkg::OP_WREN, 5, rxb[0]);
        sfsp_master_model_inst.stop();
        rd_stat(8'h00);
        $display("test opcode done");
        // Identification bytes, last one repeating
        frame(1'b0, sfsp_pkg::OP_RDID, 32'h0, 4);
        chk8("id byte 0", ID_BENCH[23:16], rxb[1]);
        chk8("id byte 1", ID_BENCH[15:8], rxb[2]);
        chk8("id byte 2", ID_BENCH[7:0], rxb[3]);
        chk8("id repeat", ID_BENCH[7:0], rxb[4]);
        $display("test id done");
        // Paused clock on write, hold with stray clocks on read
        sfsp_master_model_inst.pause_at = 5;
        wr_mem(16'h0010, 8'hc3);
        sfsp_master_model_inst.pause_at = -1;
        sfsp_master_model_inst.hold_at  = 4;
        rd_mem(1'b0, 16'h0010);
        sfsp_master_model_inst.hold_at  = -1;
        chk8("after pause and hold", 8'hc3, rxb[3]);
        chk1("read drive", 1'b1, sfsp_master_model_inst.oe_seen);
        chk1("hold drive", 1'b0, sfsp_master_model_inst.hold_oe);
        $display("test hold done");
        close_out();
    end
endmodule : sfsp_port_bench
